// [rtl/cexs_pkg.sv]
// Constants and types for the exception sequencer.
// Assumes one CPU clock; all request inputs except the reset pins are on that clock.
// Overview of operation
// - Return first copies saved status into status
// - Then run delay slot, jump to saved_pc
// - Accept saves pc/status, sets mask/privilege/bank
// - Vector is base plus 100 or 600
// - Translation miss uses 400, codes 040/060
// - Codes go to general or irq register
// - Resets load 000 or 020, jump a0000000
// - Any accepted exception sets the mask bit
// - Masked interrupts stay pending until unmask
// - Sleeping CPU takes interrupt despite the mask
// - Masked DMA address error stays pending
// - Masked user breaks are dropped, never held
// - Other masked exceptions jump to reset vector
// - Re-execution type saves own instruction address
// - Completion type saves next instruction address
// - Slot re-execution saves the delayed branch address
// - Completion in branch/slot saves branch target
// - Only taken delayed branches create a slot
// - Reset over general over interrupt
// - Eight-level order among simultaneous general exceptions
// - One exception accepted at a time
// - Illegal instruction 180, illegal slot 1a0
// - Invalid 040/060, protection 0a0/0c0, re-executed
// - First write to clean page gives 080
// - Break after execution gives 1e0, completion
package cexs_pkg;

    // Status register fields and values
    localparam int SR_BL_POS = 28;
    localparam int SR_RB_POS = 29;
    localparam int SR_MD_POS = 30;
    localparam logic [31:0] SR_RST = 32'h700000f0;
    localparam logic [31:0] VBR_RST = 32'h00000000;
    localparam logic [31:0] RESET_VEC = 32'ha0000000;

    // Vector offsets
    localparam logic [31:0] OFS_GEN = 32'h00000100;
    localparam logic [31:0] OFS_MISS = 32'h00000400;
    localparam logic [31:0] OFS_IRQ = 32'h00000600;

    // Event codes
    localparam logic [11:0] CODE_POR = 12'h000;
    localparam logic [11:0] CODE_MAN = 12'h020;
    localparam logic [11:0] CODE_TLB_RD = 12'h040;
    localparam logic [11:0] CODE_TLB_WR = 12'h060;
    localparam logic [11:0] CODE_PAGE_WR = 12'h080;
    localparam logic [11:0] CODE_PROT_RD = 12'h0a0;
    localparam logic [11:0] CODE_PROT_WR = 12'h0c0;
    localparam logic [11:0] CODE_ADDR_RD = 12'h0e0;
    localparam logic [11:0] CODE_ADDR_WR = 12'h100;
    localparam logic [11:0] CODE_TRAP = 12'h160;
    localparam logic [11:0] CODE_ILL_GEN = 12'h180;
    localparam logic [11:0] CODE_ILL_SLOT = 12'h1a0;
    localparam logic [11:0] CODE_BRK = 12'h1e0;
    localparam logic [11:0] CODE_DMA = 12'h5c0;

    // Register byte offsets
    localparam logic [7:0] OFS_SR = 8'h00;
    localparam logic [7:0] OFS_SSR = 8'h04;
    localparam logic [7:0] OFS_SPC = 8'h08;
    localparam logic [7:0] OFS_VBR = 8'h0c;
    localparam logic [7:0] OFS_GEC = 8'h10;
    localparam logic [7:0] OFS_IEC = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;

    typedef enum logic [2:0] {
        MF_ADDR = 3'h0,
        MF_MISS = 3'h1,
        MF_INV = 3'h2,
        MF_PROT = 3'h3,
        MF_PAGE = 3'h4
    } cexs_mfault_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_SLOT = 2'b01,
        S_JUMP = 2'b11
    } cexs_state_t;

    // General exception requests of the current instruction
    typedef struct packed {
        logic prior_cmpl;
        logic [11:0] prior_code;
        logic brk_pre;
        logic fetch_err;
        cexs_mfault_t fetch_kind;
        logic decode_err;
        logic decode_slot;
        logic data_err;
        cexs_mfault_t data_kind;
        logic data_wr;
        logic trap;
        logic brk_post;
    } cexs_exc_req_t;

    // Program flow around the current instruction
    typedef struct packed {
        logic [31:0] cur_pc;
        logic [31:0] next_pc;
        logic [31:0] branch_pc;
        logic [31:0] branch_target;
        logic in_slot;
        logic slot_taken;
        logic in_branch;
    } cexs_pc_info_t;

endpackage

// [rtl/cexs_sequencer.sv]
// Exception acceptance, vectoring and return sequencing for the CPU core.
// Assumes pipeline, MMU, break unit, DMA and interrupt controller on clk_i;
// manual and debug reset requests arrive as asynchronous pins.
module cexs_sequencer #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Reset pins
    input wire logic manual_rst_pin_i,
    input wire logic debug_rst_pin_i,
    // Exception sources
    input wire cexs_pkg::cexs_exc_req_t exc_i,
    input wire cexs_pkg::cexs_pc_info_t pc_i,
    input wire logic dma_err_i,
    input wire logic irq_req_i,
    input wire logic [11:0] irq_code_i,
    input wire logic sleep_i,
    // Return sequence
    input wire logic ret_i,
    input wire logic slot_done_i,
    // Program counter side
    output logic pc_load_o,
    output logic [31:0] pc_target_o,
    output logic abort_o,
    output logic taken_o,
    output logic wake_o,
    output logic in_return_o,
    output logic [31:0] sr_o
);

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_bad
        $error("ADDR_W must lie between 8 and 32");
    end

    function automatic logic [11:0] fault_code(cexs_pkg::cexs_mfault_t k, logic wr);
        case (k)
            cexs_pkg::MF_ADDR: fault_code = wr ? cexs_pkg::CODE_ADDR_WR : cexs_pkg::CODE_ADDR_RD;
            cexs_pkg::MF_PROT: fault_code = wr ? cexs_pkg::CODE_PROT_WR : cexs_pkg::CODE_PROT_RD;
            cexs_pkg::MF_PAGE: fault_code = cexs_pkg::CODE_PAGE_WR;
            default: fault_code = wr ? cexs_pkg::CODE_TLB_WR : cexs_pkg::CODE_TLB_RD;
        endcase
    endfunction

    function automatic logic [31:0] fault_ofs(cexs_pkg::cexs_mfault_t k);
        fault_ofs = (k == cexs_pkg::MF_MISS) ? cexs_pkg::OFS_MISS : cexs_pkg::OFS_GEN;
    endfunction

    // State
    logic [31:0] sr_q, sr_d, ssr_q, ssr_d, spc_q, spc_d, vbr_q, vbr_d;
    logic [11:0] gec_q, gec_d, iec_q, iec_d, irq_code_q, irq_code_d;
    logic dma_pend_q, dma_pend_d, irq_pend_q, irq_pend_d;
    cexs_pkg::cexs_state_t state_q, state_d;
    logic pc_load_q, pc_load_d, abort_q, abort_d, taken_q, taken_d, wake_q, wake_d;
    logic [31:0] target_q, target_d, prdata_q, prdata_d;
    logic [2:0] mrst_s_q, mrst_s_d, drst_s_q, drst_s_d;
    logic mrst_lvl_q, mrst_lvl_d, drst_lvl_q, drst_lvl_d;

    // Decision terms
    logic bl, slot, mrst_ev, drst_ev, apb_wr, apb_setup, addr_ok;
    logic g_hit, g_reexec, g_multi, g_dma, irq_take;
    logic [11:0] g_code;
    logic [31:0] g_ofs, save_re, save_cm;

    assign bl = sr_q[cexs_pkg::SR_BL_POS];
    assign slot = pc_i.in_slot & pc_i.slot_taken;
    assign save_re = slot ? pc_i.branch_pc : pc_i.cur_pc;
    assign save_cm = (slot | pc_i.in_branch) ? pc_i.branch_target : pc_i.next_pc;
    assign apb_wr = psel_i & penable_i & pwrite_i;
    assign apb_setup = psel_i & ~penable_i;
    assign addr_ok = (paddr_i[7:0] <= cexs_pkg::OFS_STAT) && (paddr_i[1:0] == 2'b00)
        && ((paddr_i >> 8) == '0);

    // Reset pins: three flops, a change counts when the last two agree
    always_comb begin
        mrst_s_d = {mrst_s_q[1:0], manual_rst_pin_i};
        drst_s_d = {drst_s_q[1:0], debug_rst_pin_i};
        mrst_lvl_d = (mrst_s_q[1] == mrst_s_q[2]) ? mrst_s_q[2] : mrst_lvl_q;
        drst_lvl_d = (drst_s_q[1] == drst_s_q[2]) ? drst_s_q[2] : drst_lvl_q;
        mrst_ev = mrst_lvl_d & ~mrst_lvl_q;
        drst_ev = drst_lvl_d & ~drst_lvl_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mrst_s_q <= 3'h0;
            drst_s_q <= 3'h0;
            mrst_lvl_q <= 1'b0;
            drst_lvl_q <= 1'b0;
        end else if (en_i) begin
            mrst_s_q <= mrst_s_d;
            drst_s_q <= drst_s_d;
            mrst_lvl_q <= mrst_lvl_d;
            drst_lvl_q <= drst_lvl_d;
        end
    end

    // General exception selection in fixed order
    always_comb begin
        g_hit = 1'b1;
        g_reexec = 1'b1;
        g_code = cexs_pkg::CODE_BRK;
        g_ofs = cexs_pkg::OFS_GEN;
        g_dma = 1'b0;
        if (exc_i.prior_cmpl) begin
            g_reexec = 1'b0;
            g_code = exc_i.prior_code;
        end else if (exc_i.brk_pre && !bl) begin
            g_code = cexs_pkg::CODE_BRK;
        end else if (exc_i.fetch_err) begin
            g_code = fault_code(exc_i.fetch_kind, 1'b0);
            g_ofs = fault_ofs(exc_i.fetch_kind);
        end else if (exc_i.decode_err) begin
            g_code = exc_i.decode_slot ? cexs_pkg::CODE_ILL_SLOT : cexs_pkg::CODE_ILL_GEN;
        end else if (exc_i.data_err) begin
            g_code = fault_code(exc_i.data_kind, exc_i.data_wr);
            g_ofs = fault_ofs(exc_i.data_kind);
        end else if (exc_i.trap) begin
            g_reexec = 1'b0;
            g_code = cexs_pkg::CODE_TRAP;
        end else if (exc_i.brk_post && !bl) begin
            g_reexec = 1'b0;
            g_code = cexs_pkg::CODE_BRK;
        end else if (dma_pend_q && !bl) begin
            g_reexec = 1'b0;
            g_code = cexs_pkg::CODE_DMA;
            g_dma = 1'b1;
        end else begin
            g_hit = 1'b0;
        end
        g_multi = g_hit & bl;
        irq_take = irq_pend_q & ~g_hit & (~bl | sleep_i);
    end

    // Sequencer and register file
    always_comb begin
        sr_d = sr_q;
        ssr_d = ssr_q;
        spc_d = spc_q;
        vbr_d = vbr_q;
        gec_d = gec_q;
        iec_d = iec_q;
        state_d = state_q;
        pc_load_d = 1'b0;
        abort_d = 1'b0;
        taken_d = 1'b0;
        wake_d = 1'b0;
        target_d = target_q;
        irq_code_d = irq_req_i ? irq_code_i : irq_code_q;
        irq_pend_d = irq_pend_q | irq_req_i;
        dma_pend_d = dma_pend_q | dma_err_i;
        prdata_d = prdata_q;
        if (apb_setup && !pwrite_i) begin
            case (paddr_i[7:0])
                cexs_pkg::OFS_SR: prdata_d = sr_q;
                cexs_pkg::OFS_SSR: prdata_d = ssr_q;
                cexs_pkg::OFS_SPC: prdata_d = spc_q;
                cexs_pkg::OFS_VBR: prdata_d = vbr_q;
                cexs_pkg::OFS_GEC: prdata_d = {20'h00000, gec_q};
                cexs_pkg::OFS_IEC: prdata_d = {20'h00000, iec_q};
                cexs_pkg::OFS_STAT: prdata_d = {28'h0000000, state_q, dma_pend_q, irq_pend_q};
                default: prdata_d = 32'h00000000;
            endcase
        end
        if (apb_wr && addr_ok) begin
            case (paddr_i[7:0])
                cexs_pkg::OFS_SR: sr_d = pwdata_i;
                cexs_pkg::OFS_SSR: ssr_d = pwdata_i;
                cexs_pkg::OFS_SPC: spc_d = pwdata_i;
                cexs_pkg::OFS_VBR: vbr_d = pwdata_i;
                cexs_pkg::OFS_GEC: gec_d = pwdata_i[11:0];
                default: ;
            endcase
        end
        if (drst_ev || mrst_ev) begin
            sr_d = cexs_pkg::SR_RST;
            gec_d = drst_ev ? cexs_pkg::CODE_POR : cexs_pkg::CODE_MAN;
            if (drst_ev) begin
                vbr_d = cexs_pkg::VBR_RST;
            end
            state_d = cexs_pkg::S_IDLE;
            pc_load_d = 1'b1;
            abort_d = 1'b1;
            target_d = cexs_pkg::RESET_VEC;
        end else begin
            case (state_q)
                cexs_pkg::S_IDLE: begin
                    if (g_multi) begin
                        sr_d = cexs_pkg::SR_RST;
                        pc_load_d = 1'b1;
                        abort_d = 1'b1;
                        target_d = cexs_pkg::RESET_VEC;
                    end else if (g_hit || irq_take) begin
                        spc_d = g_hit ? (g_reexec ? save_re : save_cm) : save_cm;
                        ssr_d = sr_q;
                        sr_d = sr_q;
                        sr_d[cexs_pkg::SR_BL_POS] = 1'b1;
                        sr_d[cexs_pkg::SR_MD_POS] = 1'b1;
                        sr_d[cexs_pkg::SR_RB_POS] = 1'b1;
                        if (g_hit) begin
                            gec_d = g_code;
                            target_d = 32'(vbr_q + g_ofs);
                            abort_d = g_reexec;
                            dma_pend_d = dma_err_i | (dma_pend_q & ~g_dma);
                        end else begin
                            iec_d = irq_code_q;
                            target_d = 32'(vbr_q + cexs_pkg::OFS_IRQ);
                            irq_pend_d = irq_req_i;
                            wake_d = sleep_i;
                        end
                        pc_load_d = 1'b1;
                        taken_d = 1'b1;
                    end else if (ret_i) begin
                        sr_d = ssr_q;
                        state_d = cexs_pkg::S_SLOT;
                    end
                end
                cexs_pkg::S_SLOT: begin
                    if (slot_done_i) begin
                        state_d = cexs_pkg::S_JUMP;
                    end
                end
                cexs_pkg::S_JUMP: begin
                    pc_load_d = 1'b1;
                    target_d = spc_q;
                    state_d = cexs_pkg::S_IDLE;
                end
                default: state_d = cexs_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_q <= cexs_pkg::SR_RST;
            ssr_q <= 32'h00000000;
            spc_q <= 32'h00000000;
            vbr_q <= cexs_pkg::VBR_RST;
            gec_q <= cexs_pkg::CODE_POR;
            iec_q <= 12'h000;
            irq_code_q <= 12'h000;
            irq_pend_q <= 1'b0;
            dma_pend_q <= 1'b0;
            state_q <= cexs_pkg::S_IDLE;
            pc_load_q <= 1'b0;
            abort_q <= 1'b0;
            taken_q <= 1'b0;
            wake_q <= 1'b0;
            target_q <= cexs_pkg::RESET_VEC;
            prdata_q <= 32'h00000000;
        end else if (en_i) begin
            sr_q <= sr_d;
            ssr_q <= ssr_d;
            spc_q <= spc_d;
            vbr_q <= vbr_d;
            gec_q <= gec_d;
            iec_q <= iec_d;
            irq_code_q <= irq_code_d;
            irq_pend_q <= irq_pend_d;
            dma_pend_q <= dma_pend_d;
            state_q <= state_d;
            pc_load_q <= pc_load_d;
            abort_q <= abort_d;
            taken_q <= taken_d;
            wake_q <= wake_d;
            target_q <= target_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = psel_i & penable_i;
    assign pslverr_o = psel_i & penable_i & (~addr_ok | (pwrite_i & (paddr_i[7:0] >= cexs_pkg::OFS_IEC)));
    assign pc_load_o = pc_load_q;
    assign pc_target_o = target_q;
    assign abort_o = abort_q;
    assign taken_o = taken_q;
    assign wake_o = wake_q;
    assign in_return_o = (state_q != cexs_pkg::S_IDLE);
    assign sr_o = sr_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence ret_start;
        en_i && state_q == cexs_pkg::S_IDLE && ret_i && !g_hit && !irq_take && !mrst_ev && !drst_ev;
    endsequence

    sequence slot_end;
        en_i && state_q == cexs_pkg::S_SLOT && slot_done_i && !mrst_ev && !drst_ev;
    endsequence

    chk_ret_restore: assert property (ret_start |=> sr_q == $past(ssr_q) && state_q == cexs_pkg::S_SLOT)
        else $error("status not restored on return");

    chk_ret_jump: assert property (slot_end ##1 (en_i && !mrst_ev && !drst_ev)
        |=> pc_load_o && pc_target_o == $past(spc_q) && !taken_o)
        else $error("return did not jump to saved pc");

    chk_accept_bits: assert property (en_i && state_q == cexs_pkg::S_IDLE && !g_multi && (g_hit || irq_take)
        && !mrst_ev && !drst_ev |=> taken_o && ssr_q == $past(sr_q)
        && sr_q[cexs_pkg::SR_BL_POS] && sr_q[cexs_pkg::SR_MD_POS] && sr_q[cexs_pkg::SR_RB_POS])
        else $error("accept did not save status or set mode bits");

    chk_irq_vector: assert property (en_i && state_q == cexs_pkg::S_IDLE && irq_take && !mrst_ev && !drst_ev
        |=> pc_target_o == $past(vbr_q) + cexs_pkg::OFS_IRQ && iec_q == $past(irq_code_q))
        else $error("interrupt vector or code wrong");

    chk_irq_held: assert property (irq_pend_q && bl && !sleep_i |-> !irq_take ##1 (irq_pend_q || !en_i))
        else $error("masked interrupt accepted");

    chk_brk_drop: assert property (en_i && bl && exc_i.brk_post && !exc_i.prior_cmpl && !exc_i.brk_pre
        && !exc_i.fetch_err && !exc_i.decode_err && !exc_i.data_err && !exc_i.trap && !irq_pend_q
        && state_q == cexs_pkg::S_IDLE && !mrst_ev && !drst_ev |=> !pc_load_o)
        else $error("masked user break was taken");

    chk_reset_vec: assert property (en_i && mrst_ev && !drst_ev
        |=> pc_load_o && pc_target_o == cexs_pkg::RESET_VEC && gec_q == cexs_pkg::CODE_MAN)
        else $error("manual reset did not vector correctly");

    chk_dma_held: assert property (dma_pend_q && bl |-> !g_dma ##1 (dma_pend_q || !en_i))
        else $error("masked DMA error lost or taken");

    chk_irq_prio: assert property (g_hit |-> !irq_take)
        else $error("interrupt beat a general exception");

endmodule // cexs_sequencer

// [tb/cexs_pipe_model.sv]
// Pipeline-side model: shows a general request for one cycle and ends a return's delay slot.
// Assumes the bench raises fire_i and ret_fire_i right after rising edges of clk_i.
module cexs_pipe_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bench commands
    input wire logic fire_i,
    input wire cexs_pkg::cexs_exc_req_t req_i,
    input wire logic ret_fire_i,
    input wire logic slow_i,
    // Sequencer side
    output cexs_pkg::cexs_exc_req_t exc_o,
    output logic ret_o,
    output logic slot_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // A request is dropped after the edge that takes it, so it cannot be seen twice
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exc_o <= '0;
            ret_o <= 1'b0;
            slot_done_o <= 1'b0;
            wait_q <= 4'h0;
        end else begin
            exc_o <= fire_i ? req_i : '0;
            ret_o <= ret_fire_i;
            slot_done_o <= (wait_q == 4'h1);
            if (ret_o) begin
                wait_q <= slow_i ? 4'h9 : 4'h2;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule // cexs_pipe_model

// [tb/cexs_sequencer_tb.sv]
// Self-checking bench for the exception sequencer: entry, codes, masking, priority, return, resets.
// Assumes the pipeline model beside the design and a 50 MHz clock.
module cexs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0;
    logic rst_n_i = 0;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0, fire = 0, ret_fire = 0, slow = 0;
    logic man_pin = 0, dbg_pin = 0, dma_err = 0, irq_req = 0, sleep = 0;
    logic [7:0] paddr_i = '0;
    logic [11:0] irq_code = '0;
    logic [31:0] pwdata_i = '0, prdata_o, pc_target_o, sr_o, vector_base, rd;
    logic pready_o, pslverr_o, pc_load_o, abort_o, taken_o, wake_o, in_return_o, ret, slot_done;
    logic seen, tk, wk, ab, perr;
    cexs_pkg::cexs_exc_req_t req = '0, exc;
    cexs_pkg::cexs_pc_info_t pi = '0;
    int errors = 0, check_count = 0;

    initial forever #10 clk_i = ~clk_i;

    cexs_sequencer DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(1'b1), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .manual_rst_pin_i(man_pin),
        .debug_rst_pin_i(dbg_pin), .exc_i(exc), .pc_i(pi), .dma_err_i(dma_err), .irq_req_i(irq_req),
        .irq_code_i(irq_code), .sleep_i(sleep), .ret_i(ret), .slot_done_i(slot_done),
        .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .abort_o(abort_o), .taken_o(taken_o),
        .wake_o(wake_o), .in_return_o(in_return_o), .sr_o(sr_o));
    cexs_pipe_model PIPE (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .req_i(req),
        .ret_fire_i(ret_fire), .slow_i(slow), .exc_o(exc), .ret_o(ret), .slot_done_o(slot_done));

    task automatic report_and_stop;
        $display("Checks made: %0d, mismatches: %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: seen %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        perr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wait_load(input int lim);
        seen = 0;
        for (int n = 0; n < lim && !seen; n++) begin
            @(posedge clk_i);
            #1;
            seen = (pc_load_o === 1'b1);
            tk = taken_o;
            wk = wake_o;
            ab = abort_o;
        end
    endtask

    task automatic events(input logic d, input logic i, input logic [11:0] c);
        @(posedge clk_i);
        dma_err <= d;
        irq_req <= i;
        irq_code <= c;
        @(posedge clk_i);
        dma_err <= 1'b0;
        irq_req <= 1'b0;
    endtask

    task automatic fire_req(input cexs_pkg::cexs_exc_req_t r, input cexs_pkg::cexs_pc_info_t p);
        @(posedge clk_i);
        req <= r;
        pi <= p;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    // Unmask, raise one request set, then check vector, code, saved state and status bits
    task automatic take(input cexs_pkg::cexs_exc_req_t r, input cexs_pkg::cexs_pc_info_t p,
                        input logic [31:0] tgt, input logic [11:0] code, input logic [31:0] saved_pc, input logic abt);
        apb(1'b1, cexs_pkg::OFS_SR, 32'h0);
        fire_req(r, p);
        wait_load(20);
        chk(32'({seen, tk, ab}), 32'({2'b11, abt}));
        chk(pc_target_o, tgt);
        chk(sr_o & 32'h70000000, 32'h70000000);
        apb(1'b0, cexs_pkg::OFS_GEC, 32'h0);
        chk(rd, {20'h0, code});
        apb(1'b0, cexs_pkg::OFS_SPC, 32'h0);
        chk(rd, saved_pc);
        apb(1'b0, cexs_pkg::OFS_SSR, 32'h0);
        chk(rd, 32'h0);
    endtask

    function automatic logic [11:0] mcode(input cexs_pkg::cexs_mfault_t k, input logic wr);
        case (k)
            cexs_pkg::MF_MISS, cexs_pkg::MF_INV: return wr ? 12'h060 : 12'h040;
            cexs_pkg::MF_PROT: return wr ? 12'h0c0 : 12'h0a0;
            cexs_pkg::MF_PAGE: return 12'h080;
            default: return wr ? 12'h100 : 12'h0e0;
        endcase
    endfunction

    function automatic cexs_pkg::cexs_pc_info_t rnd_pc(input logic s, input logic t, input logic b);
        return {$urandom, $urandom, $urandom, $urandom, s, t, b};
    endfunction

    initial begin
        cexs_pkg::cexs_exc_req_t r;
        cexs_pkg::cexs_pc_info_t p;
        logic [11:0] codes [6] = '{12'h1e0, 12'h0e0, 12'h180, 12'h040, 12'h160, 12'h1e0};
        void'($urandom(32'hd92b00ce));
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk(pc_target_o, 32'ha0000000);
        apb(1'b0, cexs_pkg::OFS_SR, 32'h0);
        chk(rd, 32'h700000f0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(perr), 32'h1);
        vector_base = $urandom & 32'hffffff00;
        apb(1'b1, cexs_pkg::OFS_VBR, vector_base);
        // Trap plain, in a delayed branch, and in a taken slot
        for (int i = 0; i < 3; i++) begin
            p = rnd_pc(i == 2, i == 2, i == 1);
            r = '0;
            r.trap = 1'b1;
            take(r, p, vector_base + 32'h100, 12'h160, (i > 0) ? p.branch_target : p.next_pc, 1'b0);
        end
        for (int k = 0; k < 5; k++) begin
            for (int w = 0; w < 2; w++) begin
                if (k == 4 && w == 0) continue;
                p = rnd_pc(1'b0, 1'b0, 1'b0);
                r = '0;
                r.data_err = 1'b1;
                r.data_kind = cexs_pkg::cexs_mfault_t'(k[2:0]);
                r.data_wr = w[0];
                take(r, p, vector_base + ((k == 1) ? 32'h400 : 32'h100), mcode(r.data_kind, w[0]), p.cur_pc, 1'b1);
            end
        end
        r = '0;
        r.decode_err = 1'b1;
        p = rnd_pc(1'b0, 1'b0, 1'b0);
        take(r, p, vector_base + 32'h100, 12'h180, p.cur_pc, 1'b1);
        r.decode_slot = 1'b1;
        p = rnd_pc(1'b1, 1'b1, 1'b0);
        take(r, p, vector_base + 32'h100, 12'h1a0, p.branch_pc, 1'b1);
        r = '0;
        r.fetch_err = 1'b1;
        r.fetch_kind = cexs_pkg::MF_MISS;
        p = rnd_pc(1'b1, 1'b0, 1'b0);
        take(r, p, vector_base + 32'h400, 12'h040, p.cur_pc, 1'b1);
        // Simultaneous requests, highest rank must win
        for (int i = 0; i < 6; i++) begin
            r = '0;
            r.brk_pre = (i == 0);
            r.fetch_err = (i < 2);
            r.decode_err = (i == 1 || i == 2);
            r.data_err = (i == 2 || i == 3);
            r.data_kind = cexs_pkg::MF_INV;
            r.trap = (i == 3 || i == 4);
            r.brk_post = (i >= 4);
            p = rnd_pc(1'b0, 1'b0, 1'b0);
            take(r, p, vector_base + 32'h100, codes[i], (i >= 4) ? p.next_pc : p.cur_pc, i < 4);
        end
        // Mask still set: break dropped, other exception goes to the reset vector
        r = '0;
        r.brk_post = 1'b1;
        fire_req(r, p);
        wait_load(10);
        chk(32'(seen), 32'h0);
        r = '0;
        r.decode_err = 1'b1;
        fire_req(r, p);
        wait_load(10);
        chk(32'({seen, tk}), 32'h2);
        chk(pc_target_o, 32'ha0000000);
        apb(1'b1, cexs_pkg::OFS_SR, 32'h0);
        wait_load(10);
        chk(32'(seen), 32'h0);
        apb(1'b1, cexs_pkg::OFS_SR, 32'h10000000);
        events(1'b0, 1'b1, 12'($urandom));
        wait_load(10);
        chk(32'(seen), 32'h0);
        apb(1'b0, cexs_pkg::OFS_STAT, 32'h0);
        chk(rd & 32'h3, 32'h1);
        apb(1'b1, cexs_pkg::OFS_SR, 32'h0);
        wait_load(10);
        chk(pc_target_o, vector_base + 32'h600);
        apb(1'b0, cexs_pkg::OFS_IEC, 32'h0);
        chk(rd, {20'h0, irq_code});
        events(1'b1, 1'b1, 12'($urandom));
        wait_load(10);
        chk(32'(seen), 32'h0);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, cexs_pkg::OFS_SR, 32'h0);
            wait_load(10);
            chk(pc_target_o, vector_base + (i ? 32'h600 : 32'h100));
        end
        apb(1'b0, cexs_pkg::OFS_GEC, 32'h0);
        chk(rd, 32'h5c0);
        sleep <= 1'b1;
        events(1'b0, 1'b1, 12'($urandom));
        wait_load(10);
        chk(32'({seen, wk}), 32'h3);
        sleep <= 1'b0;
        // Return with a slow and a prompt delay slot
        for (int s = 0; s < 2; s++) begin
            r = '0;
            r.trap = 1'b1;
            p = rnd_pc(1'b0, 1'b0, 1'b0);
            take(r, p, vector_base + 32'h100, 12'h160, p.next_pc, 1'b0);
            @(posedge clk_i);
            slow <= !s;
            ret_fire <= 1'b1;
            @(posedge clk_i);
            ret_fire <= 1'b0;
            for (int n = 0; n < 10 && in_return_o !== 1'b1; n++) @(posedge clk_i);
            #1;
            chk(sr_o, 32'h0);
            wait_load(20);
            chk(32'({seen, in_return_o}), 32'h2);
            chk(pc_target_o, p.next_pc);
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            man_pin <= !i;
            dbg_pin <= i;
            wait_load(12);
            man_pin <= 1'b0;
            dbg_pin <= 1'b0;
            chk(pc_target_o, 32'ha0000000);
            chk(32'({seen, tk}), 32'h2);
            apb(1'b0, cexs_pkg::OFS_GEC, 32'h0);
            chk(rd, i ? 32'h0 : 32'h20);
            apb(1'b0, cexs_pkg::OFS_VBR, 32'h0);
            chk(rd, i ? 32'h0 : vector_base);
        end
        report_and_stop;
    end

    initial begin
        #200000;
        errors++;
        report_and_stop;
    end
endmodule // cexs_sequencer_tb
